//--- verilog/wake_level_pkg.sv
// Register map, reset values and timing constants of the wake-up level block
package wake_level_pkg;

  localparam logic [7:0] OFS_CH1_THRESHOLD   = 8'h1b;
  localparam logic [7:0] OFS_CH1_BLOCK_LOW   = 8'h1c;
  localparam logic [7:0] OFS_CH1_BLOCK_HIGH  = 8'h1d;
  localparam logic [7:0] OFS_CH2_THRESHOLD   = 8'h1e;
  localparam logic [7:0] OFS_CH2_BLOCK_LOW   = 8'h1f;
  localparam logic [7:0] OFS_CH2_BLOCK_HIGH  = 8'h20;
  localparam logic [7:0] OFS_CH3_THRESHOLD   = 8'h21;
  localparam logic [7:0] OFS_CH3_BLOCK_LOW   = 8'h22;
  localparam logic [7:0] OFS_CH3_BLOCK_HIGH  = 8'h23;
  localparam logic [7:0] OFS_DET_SATURATION  = 8'h24;
  localparam logic [7:0] OFS_OBSERVE_TIME    = 8'h25;
  localparam logic [7:0] OFS_SYNC_SEARCH_TO  = 8'h26;
  localparam logic [7:0] OFS_SYNC_TIMEOUT    = 8'h27;
  localparam logic [7:0] OFS_START_ID_TO     = 8'h28;
  localparam logic [7:0] OFS_END_MSG_TO      = 8'h29;
  localparam logic [7:0] OFS_CONTROL         = 8'h40;
  localparam logic [7:0] OFS_STATUS          = 8'h41;
  localparam logic [7:0] OFS_IRQ_STATUS      = 8'h42;
  localparam logic [7:0] OFS_IRQ_MASK        = 8'h43;

  localparam logic [7:0] RST_THRESHOLD       = 8'h00;
  localparam logic [7:0] RST_BLOCK_LOW       = 8'hff;
  localparam logic [7:0] RST_BLOCK_HIGH      = 8'h00;
  localparam logic [7:0] RST_DET_SATURATION  = 8'h10;
  localparam logic [7:0] RST_OBSERVE_TIME    = 8'h00;
  localparam logic [7:0] RST_SYNC_SEARCH_TO  = 8'h87;
  localparam logic [7:0] RST_SYNC_TIMEOUT    = 8'hff;
  localparam logic [7:0] RST_START_ID_TO     = 8'h00;
  localparam logic [7:0] RST_END_MSG_TO      = 8'h00;
  localparam logic [7:0] RST_CONTROL         = 8'h04;

  // Field positions
  localparam int PRESCALER_LSB   = 5;
  localparam int CRITERION_LSB   = 0;
  localparam int CHANNEL_LSB     = 3;

  // Criterion codes
  localparam logic [2:0] CRIT_LEVEL_STRENGTH = 3'h4;
  localparam logic [2:0] CRIT_LEVEL_RECOG    = 3'h5;

  // Timing: one observation tick is 64 clocks, one time-out tick 64*512
  localparam int OBSERVE_BASE_CYCLES = 64;
  localparam int TIMEOUT_BASE_CYCLES = 64 * 512;
  localparam int OBSERVE_ZERO_COUNT  = 32;

  // Interrupt status bits
  localparam int IRQ_SYNC_TO   = 0;
  localparam int IRQ_START_TO  = 1;
  localparam int IRQ_END_TO    = 2;
  localparam int IRQ_WAKEUP    = 3;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_SYNC,
    ST_WAIT_START,
    ST_WAIT_END
  } poll_state_t;

endpackage : wake_level_pkg

//--- verilog/wake_level.sv
// Wake-up level criterion and run-mode self-polling time-out logic
`timescale 1ns/10ps
// Function
// - Channels 2 and 3 request wake-up when strength exceeds their threshold.
// - Under strength criterion, block-high register is upper blocking level; resets zero.
// - Under recognition criterion, block-high counts consecutive high sixteenth-symbol samples.
// - Each channel has 8-bit block-low level, resetting to all ones.
// - Detector peak saturates at programmable threshold, reset 0x10.
// - Prescaler codes 0 to 7 give factors 4 through 512.
// - Observation time is N times factor times 64 clocks.
// - Observation count zero counts as 32.
// - Sync search time-out in sixteenth bits, reset 0x87.
// - Sync time-out without symbol sync returns to self-polling.
// - Sync time-out is setting times 64*512 clocks; zero disables; reset 0xff.
// - Start-id time-out after sync without start id returns; zero disables.
// - End-of-message time-out is setting times 64*512*2 clocks; zero disables.
// - Only the sync time-out timer reloads at each run-mode cycle start; start-id loads on sync, end-of-message on start id.
// - Channel 1 also requests wake-up above its own threshold.
// - Criterion code 100 selects strength, 101 selects recognition.
module wake_level #(
  parameter int TIMEOUT_BASE = wake_level_pkg::TIMEOUT_BASE_CYCLES
) (
  input  wire logic       clk_sys_i,
  input  wire logic       resetn_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic [7:0] strength_i,
  input  wire logic       recog_i,
  input  wire logic       sample_tick_i,
  input  wire logic [7:0] det_peak_i,
  input  wire logic       cycle_start_i,
  input  wire logic       sync_found_i,
  input  wire logic       start_id_found_i,
  input  wire logic       end_msg_found_i,
  output logic      [7:0] det_peak_sat_o,
  output logic      [7:0] sync_search_timeout_o,
  output logic            wakeup_o,
  output logic            fallback_o,
  output logic            irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] ch1_wake_threshold;
  logic [7:0] ch1_block_low;
  logic [7:0] ch1_block_high;
  logic [7:0] ch2_wake_threshold;
  logic [7:0] ch2_block_low;
  logic [7:0] ch2_block_high;
  logic [7:0] ch3_wake_threshold;
  logic [7:0] ch3_block_low;
  logic [7:0] ch3_block_high;
  logic [7:0] detector_saturation;
  logic [7:0] level_observe_time;
  logic [7:0] sync_search_timeout;
  logic [7:0] sync_timeout_timer;
  logic [7:0] start_id_timeout_timer;
  logic [7:0] end_msg_timeout_timer;
  logic [7:0] control;
  logic [3:0] irq_status;
  logic [3:0] irq_mask;

  logic [2:0] wake_criterion_select;
  logic [1:0] active_channel;
  logic [2:0] observe_prescaler;
  logic [4:0] observe_count;
  assign wake_criterion_select = control[wake_level_pkg::CRITERION_LSB +: 3];
  assign active_channel        = control[wake_level_pkg::CHANNEL_LSB +: 2];
  assign observe_prescaler     = level_observe_time[wake_level_pkg::PRESCALER_LSB +: 3];
  assign observe_count         = level_observe_time[4:0];

  logic [3:0] irq_events;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ch1_wake_threshold     <= wake_level_pkg::RST_THRESHOLD;
      ch1_block_low          <= wake_level_pkg::RST_BLOCK_LOW;
      ch1_block_high         <= wake_level_pkg::RST_BLOCK_HIGH;
      ch2_wake_threshold     <= wake_level_pkg::RST_THRESHOLD;
      ch2_block_low          <= wake_level_pkg::RST_BLOCK_LOW;
      ch2_block_high         <= wake_level_pkg::RST_BLOCK_HIGH;
      ch3_wake_threshold     <= wake_level_pkg::RST_THRESHOLD;
      ch3_block_low          <= wake_level_pkg::RST_BLOCK_LOW;
      ch3_block_high         <= wake_level_pkg::RST_BLOCK_HIGH;
      detector_saturation    <= wake_level_pkg::RST_DET_SATURATION;
      level_observe_time     <= wake_level_pkg::RST_OBSERVE_TIME;
      sync_search_timeout    <= wake_level_pkg::RST_SYNC_SEARCH_TO;
      sync_timeout_timer     <= wake_level_pkg::RST_SYNC_TIMEOUT;
      start_id_timeout_timer <= wake_level_pkg::RST_START_ID_TO;
      end_msg_timeout_timer  <= wake_level_pkg::RST_END_MSG_TO;
      control                <= wake_level_pkg::RST_CONTROL;
      irq_mask               <= 4'h0;
    end else if (wr_i) begin
      if (addr_i == wake_level_pkg::OFS_CH1_THRESHOLD) ch1_wake_threshold <= wdata_i;
      else if (addr_i == wake_level_pkg::OFS_CH1_BLOCK_LOW) ch1_block_low <= wdata_i;
      else if (addr_i == wake_level_pkg::OFS_CH1_BLOCK_HIGH) ch1_block_high <= wdata_i;
      else if (addr_i == wake_level_pkg::OFS_CH2_THRESHOLD) ch2_wake_threshold <= wdata_i;
      else if (addr_i == wake_level_pkg::OFS_CH2_BLOCK_LOW) ch2_block_low <= wdata_i;
      else if (addr_i == wake_level_pkg::OFS_CH2_BLOCK_HIGH) ch2_block_high <= wdata_i;
      else if (addr_i == wake_level_pkg::OFS_CH3_THRESHOLD) ch3_wake_threshold <= wdata_i;
      else if (addr_i == wake_level_pkg::OFS_CH3_BLOCK_LOW) ch3_block_low <= wdata_i;
      else if (addr_i == wake_level_pkg::OFS_CH3_BLOCK_HIGH) ch3_block_high <= wdata_i;
      else if (addr_i == wake_level_pkg::OFS_DET_SATURATION) detector_saturation <= wdata_i;
      else if (addr_i == wake_level_pkg::OFS_OBSERVE_TIME) level_observe_time <= wdata_i;
      else if (addr_i == wake_level_pkg::OFS_SYNC_SEARCH_TO) sync_search_timeout <= wdata_i;
      else if (addr_i == wake_level_pkg::OFS_SYNC_TIMEOUT) sync_timeout_timer <= wdata_i;
      else if (addr_i == wake_level_pkg::OFS_START_ID_TO) start_id_timeout_timer <= wdata_i;
      else if (addr_i == wake_level_pkg::OFS_END_MSG_TO) end_msg_timeout_timer <= wdata_i;
      else if (addr_i == wake_level_pkg::OFS_CONTROL) control <= wdata_i;
      else if (addr_i == wake_level_pkg::OFS_IRQ_MASK) irq_mask <= wdata_i[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readback; registers 0x1b to 0x29 are write-only and read zero
  logic [1:0] poll_code;
  logic [7:0] status_word;
  assign status_word = {4'h0, wakeup_o, fallback_o, poll_code};

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) rdata_o <= 8'h00;
    else if (rd_i && addr_i == wake_level_pkg::OFS_STATUS) rdata_o <= status_word;
    else if (rd_i && addr_i == wake_level_pkg::OFS_IRQ_STATUS) rdata_o <= {4'h0, irq_status};
    else if (rd_i && addr_i == wake_level_pkg::OFS_IRQ_MASK) rdata_o <= {4'h0, irq_mask};
    else if (rd_i && addr_i == wake_level_pkg::OFS_CONTROL) rdata_o <= control;
    else rdata_o <= 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [7:0] strength_m, strength_s;
  logic [7:0] peak_m, peak_s;
  logic [6:0] ev_m, ev_s;
  logic       tick_d, cyc_d;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      strength_m <= 8'h00;
      strength_s <= 8'h00;
      peak_m     <= 8'h00;
      peak_s     <= 8'h00;
      ev_m       <= 7'h00;
      ev_s       <= 7'h00;
      tick_d     <= 1'b0;
      cyc_d      <= 1'b0;
    end else begin
      strength_m <= strength_i;
      strength_s <= strength_m;
      peak_m     <= det_peak_i;
      peak_s     <= peak_m;
      ev_m       <= {recog_i, sample_tick_i, cycle_start_i, sync_found_i,
                     start_id_found_i, end_msg_found_i, 1'b0};
      ev_s       <= ev_m;
      tick_d     <= ev_s[5];
      cyc_d      <= ev_s[4];
    end
  end

  logic recog_s, tick_s, cyc_s, sync_s, start_s, end_s;
  assign recog_s = ev_s[6];
  assign tick_s  = ev_s[5];
  assign cyc_s   = ev_s[4];
  assign sync_s  = ev_s[3];
  assign start_s = ev_s[2];
  assign end_s   = ev_s[1];

  logic tick_p, cyc_p;
  assign tick_p = tick_s & ~tick_d;
  assign cyc_p  = cyc_s & ~cyc_d;

  ////////////////////////////////////////////////////////////////////////////
  // Detector saturation and sync search time-out outputs
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      det_peak_sat_o        <= 8'h00;
      sync_search_timeout_o <= wake_level_pkg::RST_SYNC_SEARCH_TO;
    end else begin
      det_peak_sat_o <= (peak_s > detector_saturation) ? detector_saturation : peak_s;
      sync_search_timeout_o <= sync_search_timeout;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Observation window
  function automatic logic [20:0] observe_length(input logic [2:0] ps, input logic [4:0] n);
    logic [5:0] cnt;
    cnt = (n == 5'h00) ? 6'(wake_level_pkg::OBSERVE_ZERO_COUNT) : {1'b0, n};
    // Factor 4 << ps times 64 clocks; 32 << 15 needs 21 bits
    observe_length = 21'(cnt) << ({1'b0, ps} + 4'h8);
  endfunction : observe_length

  logic [20:0] observe_cnt;
  logic        observing;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      observe_cnt <= 21'h0;
      observing   <= 1'b0;
    end else if (cyc_p) begin
      observe_cnt <= observe_length(observe_prescaler, observe_count);
      observing   <= 1'b1;
    end else if (observing) begin
      observe_cnt <= observe_cnt - 21'h1;
      observing   <= (observe_cnt != 21'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Level criterion evaluation
  logic [7:0] sel_thr, sel_low, sel_high;

  always_comb begin
    sel_thr  = ch1_wake_threshold;
    sel_low  = ch1_block_low;
    sel_high = ch1_block_high;
    case (active_channel)
      2'h1: begin
        sel_thr  = ch2_wake_threshold;
        sel_low  = ch2_block_low;
        sel_high = ch2_block_high;
      end
      2'h2: begin
        sel_thr  = ch3_wake_threshold;
        sel_low  = ch3_block_low;
        sel_high = ch3_block_high;
      end
      default: begin
      end
    endcase
  end

  logic [7:0] recog_run;
  logic       level_hit;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      recog_run <= 8'h00;
    end else if (!recog_s || !observing) begin
      recog_run <= 8'h00;
    end else if (tick_p && recog_run != 8'hff) begin
      recog_run <= recog_run + 8'h1;
    end
  end

  always_comb begin
    level_hit = 1'b0;
    case (wake_criterion_select)
      wake_level_pkg::CRIT_LEVEL_STRENGTH: begin
        // Zero upper level leaves the band open above
        level_hit = (strength_s > sel_thr) && (strength_s <= sel_low)
                    && (sel_high == 8'h00 || strength_s < sel_high);
      end
      wake_level_pkg::CRIT_LEVEL_RECOG: begin
        level_hit = recog_s && (recog_run >= sel_high);
      end
      default: level_hit = 1'b0;
    endcase
  end

  logic wake_evt;
  assign wake_evt = observing && level_hit && !wakeup_o;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wakeup_o <= 1'b0;
    end else if (cyc_p) begin
      wakeup_o <= 1'b0;
    end else if (wake_evt) begin
      wakeup_o <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run-mode self-polling time-outs
  wake_level_pkg::poll_state_t state;
  logic [25:0] to_cnt;
  logic        expire;

  function automatic logic [25:0] timeout_len(input logic [7:0] set, input logic dbl);
    timeout_len = 26'(set) * 26'(TIMEOUT_BASE) << dbl;
  endfunction : timeout_len

  assign expire = (to_cnt == 26'h1);
  assign poll_code = state;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state  <= wake_level_pkg::ST_IDLE;
      to_cnt <= 26'h0;
    end else if (cyc_p) begin
      state  <= wake_level_pkg::ST_WAIT_SYNC;
      to_cnt <= timeout_len(sync_timeout_timer, 1'b0);
    end else begin
      if (to_cnt > 26'h1) begin
        to_cnt <= to_cnt - 26'h1;
      end
      case (state)
        wake_level_pkg::ST_WAIT_SYNC: begin
          if (sync_s) begin
            state  <= wake_level_pkg::ST_WAIT_START;
            to_cnt <= timeout_len(start_id_timeout_timer, 1'b0);
          end else if (expire) begin
            state  <= wake_level_pkg::ST_IDLE;
            to_cnt <= 26'h0;
          end
        end
        wake_level_pkg::ST_WAIT_START: begin
          if (start_s) begin
            state  <= wake_level_pkg::ST_WAIT_END;
            to_cnt <= timeout_len(end_msg_timeout_timer, 1'b1);
          end else if (expire) begin
            state  <= wake_level_pkg::ST_IDLE;
            to_cnt <= 26'h0;
          end
        end
        wake_level_pkg::ST_WAIT_END: begin
          if (end_s || expire) begin
            state  <= wake_level_pkg::ST_IDLE;
            to_cnt <= 26'h0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  logic sync_exp, start_exp, end_exp;
  assign sync_exp  = !cyc_p && expire && state == wake_level_pkg::ST_WAIT_SYNC && !sync_s;
  assign start_exp = !cyc_p && expire && state == wake_level_pkg::ST_WAIT_START && !start_s;
  assign end_exp   = !cyc_p && expire && state == wake_level_pkg::ST_WAIT_END && !end_s;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fallback_o <= 1'b0;
    end else begin
      fallback_o <= sync_exp | start_exp | end_exp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: set wins over write-one-to-clear
  assign irq_events = {wake_evt, end_exp, start_exp, sync_exp};

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_status <= 4'h0;
    end else if (wr_i && addr_i == wake_level_pkg::OFS_IRQ_STATUS) begin
      irq_status <= (irq_status & ~wdata_i[3:0]) | irq_events;
    end else begin
      irq_status <= irq_status | irq_events;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status & irq_mask);
    end
  end

endmodule : wake_level

//--- tb/wake_level_checker.sv
// Port-level checker of the wake-up level block
`timescale 1ns/10ps
module wake_level_checker #(
  parameter int TIMEOUT_BASE = 4
) (
  input  wire logic       clk_sys_i,
  input  wire logic       resetn_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic [7:0] rdata_o,
  input  wire logic [7:0] det_peak_i,
  input  wire logic       cycle_start_i,
  input  wire logic       sync_found_i,
  input  wire logic [7:0] det_peak_sat_o,
  input  wire logic [7:0] sync_search_timeout_o,
  input  wire logic       fallback_o,
  input  wire logic       irq_o
);
  localparam int EXP_LO = TIMEOUT_BASE;
  localparam int EXP_HI = TIMEOUT_BASE + 6;
  logic [7:0] sat, mask, sync, telegram_start_identifier, end_of_message, peak_q;
  logic [2:0] calm, zcnt;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////
  // Shadows of the clamp, time-out and interrupt mask settings
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sat  <= 8'h10;
      mask <= 8'h00;
      sync <= 8'hff;
      telegram_start_identifier  <= 8'h00;
      end_of_message  <= 8'h00;
    end else if (wr_i) begin
      case (addr_i)
        8'h24:   sat <= wdata_i;
        8'h27:   sync <= wdata_i;
        8'h28:   telegram_start_identifier <= wdata_i;
        8'h29:   end_of_message <= wdata_i;
        8'h43:   mask <= wdata_i;
        default: ;
      endcase
    end
  end
  // Cycles since the clamp inputs last moved
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      peak_q <= 8'h00;
      calm   <= 3'h0;
    end else begin
      peak_q <= det_peak_i;
      if (det_peak_i != peak_q || (wr_i && addr_i == 8'h24)) calm <= 3'h0;
      else if (calm != 3'h7) calm <= calm + 3'h1;
    end
  end
  // Cycles since a cycle start with every timer disabled
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) zcnt <= 3'h0;
    else if (wr_i && addr_i inside {[8'h27:8'h29]}) zcnt <= 3'h0;
    else if (zcnt == 3'h0 && cycle_start_i && {sync, telegram_start_identifier, end_of_message} == 24'h0) zcnt <= 3'h1;
    else if (zcnt != 3'h0 && zcnt != 3'h7) zcnt <= zcnt + 3'h1;
  end
  ////////////////////////////////////////
  sequence s_sync_unit_start;
    $rose(cycle_start_i) && sync == 8'h01 && !sync_found_i;
  endsequence
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data without a read");
  a_config_hidden: assert property ($past(rd_i) && $past(addr_i) inside {[8'h1b:8'h29]}
    |-> rdata_o == 8'h00) else $error("write-only register read back");
  a_unmapped_zero: assert property ($past(rd_i) && $past(addr_i) > 8'h43 |-> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_sat_clamp: assert property (calm == 3'h7 |->
    det_peak_sat_o == ((peak_q < sat) ? peak_q : sat)) else $error("peak clamp wrong");
  a_search_load: assert property (wr_i && addr_i == 8'h26 |-> ##2
    sync_search_timeout_o == $past(wdata_i, 2)) else $error("search setting not loaded");
  a_search_hold: assert property (!$past(wr_i, 2) |-> $stable(sync_search_timeout_o))
    else $error("search setting moved");
  a_fallback_pulse: assert property (fallback_o |=> !fallback_o)
    else $error("fallback longer than one cycle");
  a_irq_masked: assert property (mask == 8'h00 && $past(mask) == 8'h00 |-> !irq_o)
    else $error("interrupt while fully masked");
  a_zero_disable: assert property (zcnt == 3'h7 |-> !fallback_o)
    else $error("fallback with timers disabled");
  a_sync_expiry: assert property (s_sync_unit_start |-> ##[EXP_LO:EXP_HI] fallback_o)
    else $error("sync time-out length wrong");
endmodule : wake_level_checker

bind wake_level wake_level_checker #(.TIMEOUT_BASE(TIMEOUT_BASE)) i_checker (
  .clk_sys_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .det_peak_i,
  .cycle_start_i, .sync_found_i, .det_peak_sat_o, .sync_search_timeout_o, .fallback_o, .irq_o
);

//--- tb/wake_level_tb.sv
// Self-checking bench of the wake-up level block
`timescale 1ns/10ps
module wake_level_tb;
  localparam int TB_BASE = 4;
  logic        clk_sys_i, resetn_i, wr_i, rd_i, recog_i, sample_tick_i, cycle_start_i;
  logic        sync_found_i, start_id_found_i, end_msg_found_i, wakeup_o, fallback_o, irq_o;
  logic [7:0]  addr_i, wdata_i, strength_i, det_peak_i, rdata_o, det_peak_sat_o;
  logic [7:0]  sync_search_timeout_o, v, thr, lo, hi;
  logic [7:0]  st [6];
  logic [31:0] rnd;
  int          bad_count, checks_done, fb_count, n, mark;

  wake_level #(.TIMEOUT_BASE(TB_BASE)) i_dut (
    .clk_sys_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .strength_i, .recog_i,
    .sample_tick_i, .det_peak_i, .cycle_start_i, .sync_found_i, .start_id_found_i,
    .end_msg_found_i, .det_peak_sat_o, .sync_search_timeout_o, .wakeup_o, .fallback_o, .irq_o
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    if (fallback_o === 1'b1) fb_count++;
  end
  ////////////////////////////////////////
  function automatic logic [7:0] rand8();
    rnd = (rnd >> 1) ^ (rnd[0] ? 32'h8020_0003 : 32'h0);
    return rnd[7:0];
  endfunction : rand8
  function automatic logic wake_exp(input logic [7:0] s, t, l, h);
    return s > t && s <= l && (h == 8'h00 || s < h);
  endfunction : wake_exp
  function automatic int obs_len(input int p);
    return p < 6 ? 64 * (4 << p) : 32 * 4 * 64;
  endfunction : obs_len
  function automatic int to_len(input int k);
    return (k == 1 ? 2 : 1) * TB_BASE * (k == 2 ? 2 : 1);
  endfunction : to_len
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys_i);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask : rd
  task automatic pulse();
    @(posedge clk_sys_i) cycle_start_i <= 1'b1;
    @(posedge clk_sys_i) cycle_start_i <= 1'b0;
  endtask : pulse
  task automatic tick();
    @(posedge clk_sys_i) sample_tick_i <= 1'b1;
    cyc(1);
    @(posedge clk_sys_i) sample_tick_i <= 1'b0;
    cyc(1);
  endtask : tick
  task automatic wait_fb(input int lim);
    n = 0;
    while (fallback_o !== 1'b1) begin
      @(posedge clk_sys_i);
      #1 n++;
      if (n > lim) begin
        bad_count++;
        end_of_test();
      end
    end
  endtask : wait_fb
  ////////////////////////////////////////
  initial begin
    {resetn_i, wr_i, rd_i, recog_i, sample_tick_i, cycle_start_i} = '0;
    {sync_found_i, start_id_found_i, end_msg_found_i} = '0;
    {addr_i, wdata_i, strength_i} = '0;
    det_peak_i = 8'hff;
    {bad_count, checks_done, fb_count} = '0;
    rnd = 32'h374b;
    repeat (3) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    cyc(6);
    check("search setting", sync_search_timeout_o, 8'h87);
    check("peak clamp", det_peak_sat_o, 8'h10);
    rd(wake_level_pkg::OFS_CONTROL);
    check("control", v, wake_level_pkg::RST_CONTROL);
    for (int a = 8'h1b; a <= 8'h29; a++) begin
      rd(8'(a));
      check("write-only read", v, 8'h00);
    end
    wr(8'h80, 8'h5a);
    rd(8'h80);
    check("unmapped read", v, 8'h00);
    pulse();
    cyc(6);
    strength_i <= 8'hff;
    cyc(8);
    check("wake at reset levels", wakeup_o, 1'b1);
    $display("Test reset done");
    repeat (8) begin
      thr = rand8();
      lo = rand8();
      wr(8'h24, thr);
      det_peak_i <= lo;
      cyc(6);
      check("peak clamp", det_peak_sat_o, lo < thr ? lo : thr);
      wr(8'h26, lo);
      #11 check("search setting", sync_search_timeout_o, lo);
    end
    $display("Test settings done");
    wr(8'h27, 8'h00);
    for (int c = 0; c < 3; c++) begin
      for (int r = 0; r < 9; r++) wr(8'h1b + 8'(r), r % 3 == 2 ? 8'h00 : 8'hff);
      thr = rand8();
      lo = rand8() | 8'h80;
      hi = rand8();
      wr(8'h1b + 8'(3 * c), thr);
      wr(8'h1c + 8'(3 * c), lo);
      wr(8'h1d + 8'(3 * c), hi);
      wr(8'h40, 8'(c << 3) | 8'h04);
      st = '{thr, thr + 8'h01, lo, lo + 8'h01, hi - 8'h01, rand8()};
      for (int i = 0; i < 6; i++) begin
        strength_i <= 8'h00;
        pulse();
        cyc(6);
        strength_i <= st[i];
        cyc(8);
        check("wake level", wakeup_o, wake_exp(st[i], thr, lo, hi));
      end
    end
    $display("Test channels done");
    wr(8'h40, 8'h0c);
    wr(8'h1e, 8'h10);
    wr(8'h1f, 8'hff);
    wr(8'h20, 8'h00);
    for (int p = 0; p < 7; p++) begin
      wr(8'h25, p < 6 ? {3'(p), 5'h01} : 8'h00);
      for (int s = 0; s < 2; s++) begin
        strength_i <= 8'h00;
        pulse();
        cyc(obs_len(p) - 10 + 20 * s);
        strength_i <= 8'h80;
        cyc(8);
        check("observation window", wakeup_o, s == 0);
      end
    end
    $display("Test window done");
    strength_i <= 8'h00;
    wr(8'h40, 8'h0d);
    wr(8'h20, 8'h05);
    pulse();
    cyc(4);
    recog_i <= 1'b1;
    repeat (4) tick();
    check("short recognition run", wakeup_o, 1'b0);
    recog_i <= 1'b0;
    tick();
    recog_i <= 1'b1;
    repeat (5) tick();
    cyc(4);
    check("recognition run", wakeup_o, 1'b1);
    recog_i <= 1'b0;
    $display("Test recognition done");
    wr(8'h40, 8'h04);
    wr(8'h42, 8'hff);
    for (int k = 0; k < 3; k++) begin
      wr(8'h27, k == 0 ? 8'h01 : 8'h00);
      wr(8'h28, k == 1 ? 8'h02 : 8'h00);
      wr(8'h29, k == 2 ? 8'h01 : 8'h00);
      {sync_found_i, start_id_found_i} <= 2'b00;
      pulse();
      if (k > 0) cyc(6);
      if (k > 0) sync_found_i <= 1'b1;
      if (k > 1) cyc(6);
      if (k > 1) start_id_found_i <= 1'b1;
      wait_fb(40);
      check("time-out length", n >= to_len(k) && n <= to_len(k) + 7, 1'b1);
      cyc(2);
      rd(8'h42);
      check("event status", v, 8'(1 << k));
      if (k == 0) check("masked line", irq_o, 1'b0);
      wr(8'h43, 8'h07);
      cyc(2);
      check("event line", irq_o, 1'b1);
      wr(8'h42, 8'(1 << k));
      cyc(2);
      check("event line cleared", irq_o, 1'b0);
    end
    {sync_found_i, start_id_found_i} <= 2'b00;
    wr(8'h27, 8'h03);
    wr(8'h29, 8'h00);
    mark = fb_count;
    repeat (6) begin
      pulse();
      cyc(6);
    end
    check("reload keeps quiet", fb_count, mark);
    wait_fb(40);
    wr(8'h27, 8'h00);
    wr(8'h29, 8'h01);
    mark = fb_count;
    pulse();
    cyc(4);
    sync_found_i <= 1'b1;
    cyc(4);
    start_id_found_i <= 1'b1;
    cyc(2);
    end_msg_found_i <= 1'b1;
    cyc(40);
    check("message end stops timer", fb_count, mark);
    {sync_found_i, start_id_found_i, end_msg_found_i} <= 3'b000;
    wr(8'h29, 8'h00);
    pulse();
    cyc(200);
    check("disabled timers", fb_count, mark);
    $display("Test time-outs done");
    end_of_test();
  end
  initial begin
    #900us;
    bad_count++;
    end_of_test();
  end
endmodule : wake_level_tb
